// ==== include/pin_mux_pkg.sv ====
// Constants and types for the card port 0 pin multiplexer and flag pin.
// Assumes a single peripheral clock domain; no software-visible registers here.
package pin_mux_pkg;

  // Function select field width and codes (values are a plain choice)
  localparam int SEL_W = 2;
  localparam logic [1:0] SEL_CARD = 2'h0;
  localparam logic [1:0] SEL_AUDIO = 2'h1;
  localparam logic [1:0] SEL_GPIO = 2'h2;

  // Pin indices within the six-pin group
  localparam int PIN_CNT = 6;
  localparam int PIN_CLK = 0;
  localparam int PIN_CMD = 1;
  localparam int PIN_D0 = 2;
  localparam int PIN_D1 = 3;
  localparam int PIN_D2 = 4;
  localparam int PIN_D3 = 5;

  // Card data bus width
  localparam int DATA_W = 4;

  // Reset values
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [5:0] PD_INHIBIT_RESET = 6'h00;
  localparam logic FLAG_RESET = 1'h1;

  // Bit of status register 1 whose write clears the flag
  localparam int FLAG_CLEAR_BIT = 13;

  // Decoded function of the pin group, one-hot
  typedef enum logic [2:0] {
    FUNC_CARD = 3'h1,
    FUNC_AUDIO = 3'h2,
    FUNC_GPIO = 3'h4
  } pin_func_t;

endpackage

// ==== include/pin_path_if.sv ====
// Per-pin drive path between the multiplexer and the pad stage.
// Assumes one pad stage per pin group, same clock as the multiplexer.
`timescale 1ns/1ps
interface pin_path_if;
  logic [5:0] out;
  logic [5:0] oe;
  logic [5:0] pd_inhibit;
  logic [5:0] pad_out;
  logic [5:0] pad_oe;
  logic [5:0] pad_pd_en;
  modport mux (output out, output oe, output pd_inhibit,
               input pad_out, input pad_oe, input pad_pd_en);
  modport pad (input out, input oe, input pd_inhibit,
               output pad_out, output pad_oe, output pad_pd_en);
endinterface

// ==== rtl/pin_pad_stage.sv ====
// Registered pad stage: drive, enable and pulldown for the six pins.
// Assumes the interface is fed by the multiplexer in the same clock domain.
`timescale 1ns/1ps
module pin_pad_stage (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Path from the multiplexer
  pin_path_if.pad path
);

  logic [5:0] out_q, out_d;
  logic [5:0] oe_q, oe_d;
  logic [5:0] pd_q, pd_d;

  always_comb begin
    out_d = path.out;
    oe_d = path.oe;
    // Pulldown only on an undriven pin and not inhibited
    pd_d = ~path.pd_inhibit & ~path.oe;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_q <= 6'h00;
      oe_q <= 6'h00;
      pd_q <= ~pin_mux_pkg::PD_INHIBIT_RESET;
    end else if (clk_en) begin
      out_q <= out_d;
      oe_q <= oe_d;
      pd_q <= pd_d;
    end
  end

  assign path.pad_out = out_q;
  assign path.pad_oe = oe_q;
  assign path.pad_pd_en = pd_q;

endmodule

// ==== rtl/card_port0_pin_mux.sv ====
// Card port 0 pin function multiplexer and external flag output pin.
// Assumes all functional inputs are synchronous to mclk.
// What this block does
// - Clock pin: card clock, audio clock, or pin 0
// - Command pin: card command, frame sync, or pin 1
// - Data 3 and 2: card or pins 5, 4
// - Data 1, 0: card, audio rx/tx, pins 3, 2
// - Card mode: four data lines, bidirectional bus
// - Function picked by serial port 0 select field
// - Per-pin pulldown inhibit bits from software
// - Bit-set instruction drives flag high
// - Bit-clear or status bit 13 write: low
// - Flag high impedance only during boundary scan
// - Flag is the registered set/clear flag output
`timescale 1ns/1ps
module card_port0_pin_mux (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Configuration
  input wire logic [1:0] serial_port0_function_select,
  input wire logic [5:0] pulldown_inhibit_register_1,
  // Card controller side
  input wire logic card_clk_out,
  input wire logic card_cmd_out,
  input wire logic card_cmd_oe,
  output logic card_cmd_in,
  input wire logic [3:0] card_data_out,
  input wire logic [3:0] card_data_oe,
  output logic [3:0] card_data_in,
  // Audio port side
  input wire logic audio_clk_out,
  input wire logic audio_clk_oe,
  output logic audio_clk_in,
  input wire logic audio_fs_out,
  input wire logic audio_fs_oe,
  output logic audio_fs_in,
  output logic audio_rx_in,
  input wire logic audio_tx_out,
  input wire logic audio_tx_oe,
  // General pin side
  input wire logic [5:0] gpio_out,
  input wire logic [5:0] gpio_oe,
  output logic [5:0] gpio_in,
  // Pins
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe,
  output logic [5:0] pin_pd_en,
  // Flag pin control
  input wire logic flag_set,
  input wire logic flag_clear,
  input wire logic status1_write,
  input wire logic [15:0] status1_wdata,
  input wire logic boundary_scan,
  output logic external_flag_output,
  output logic external_flag_oe
);

  pin_path_if path ();

  // Decoded function of the whole group
  pin_mux_pkg::pin_func_t func;
  logic flag_q;
  logic flag_d;
  logic [5:0] sel_in;

  function automatic pin_mux_pkg::pin_func_t decode_sel(input logic [1:0] sel);
    case (sel)
      pin_mux_pkg::SEL_CARD: decode_sel = pin_mux_pkg::FUNC_CARD;
      pin_mux_pkg::SEL_AUDIO: decode_sel = pin_mux_pkg::FUNC_AUDIO;
      default: decode_sel = pin_mux_pkg::FUNC_GPIO;
    endcase
  endfunction

  assign func = decode_sel(serial_port0_function_select);

  // Drive paths per function
  always_comb begin
    path.out = 6'h00;
    path.oe = 6'h00;
    unique case (func)
      pin_mux_pkg::FUNC_CARD: begin
        // Card clock always driven toward the card
        path.out[pin_mux_pkg::PIN_CLK] = card_clk_out;
        path.oe[pin_mux_pkg::PIN_CLK] = 1'h1;
        path.out[pin_mux_pkg::PIN_CMD] = card_cmd_out;
        path.oe[pin_mux_pkg::PIN_CMD] = card_cmd_oe;
        // Four data lines as one bus, bit 0 on data 0
        path.out[pin_mux_pkg::PIN_D0] = card_data_out[0];
        path.oe[pin_mux_pkg::PIN_D0] = card_data_oe[0];
        path.out[pin_mux_pkg::PIN_D1] = card_data_out[1];
        path.oe[pin_mux_pkg::PIN_D1] = card_data_oe[1];
        path.out[pin_mux_pkg::PIN_D2] = card_data_out[2];
        path.oe[pin_mux_pkg::PIN_D2] = card_data_oe[2];
        path.out[pin_mux_pkg::PIN_D3] = card_data_out[3];
        path.oe[pin_mux_pkg::PIN_D3] = card_data_oe[3];
      end
      pin_mux_pkg::FUNC_AUDIO: begin
        path.out[pin_mux_pkg::PIN_CLK] = audio_clk_out;
        path.oe[pin_mux_pkg::PIN_CLK] = audio_clk_oe;
        path.out[pin_mux_pkg::PIN_CMD] = audio_fs_out;
        path.oe[pin_mux_pkg::PIN_CMD] = audio_fs_oe;
        // Transmit on data 0, receive only on data 1
        path.out[pin_mux_pkg::PIN_D0] = audio_tx_out;
        path.oe[pin_mux_pkg::PIN_D0] = audio_tx_oe;
        path.out[pin_mux_pkg::PIN_D1] = 1'h0;
        path.oe[pin_mux_pkg::PIN_D1] = 1'h0;
        // Data 3 and 2 have no audio use and stay undriven
        path.out[pin_mux_pkg::PIN_D2] = 1'h0;
        path.oe[pin_mux_pkg::PIN_D2] = 1'h0;
        path.out[pin_mux_pkg::PIN_D3] = 1'h0;
        path.oe[pin_mux_pkg::PIN_D3] = 1'h0;
      end
      pin_mux_pkg::FUNC_GPIO: begin
        path.out[pin_mux_pkg::PIN_CLK] = gpio_out[pin_mux_pkg::PIN_CLK];
        path.oe[pin_mux_pkg::PIN_CLK] = gpio_oe[pin_mux_pkg::PIN_CLK];
        path.out[pin_mux_pkg::PIN_CMD] = gpio_out[pin_mux_pkg::PIN_CMD];
        path.oe[pin_mux_pkg::PIN_CMD] = gpio_oe[pin_mux_pkg::PIN_CMD];
        path.out[pin_mux_pkg::PIN_D0] = gpio_out[pin_mux_pkg::PIN_D0];
        path.oe[pin_mux_pkg::PIN_D0] = gpio_oe[pin_mux_pkg::PIN_D0];
        path.out[pin_mux_pkg::PIN_D1] = gpio_out[pin_mux_pkg::PIN_D1];
        path.oe[pin_mux_pkg::PIN_D1] = gpio_oe[pin_mux_pkg::PIN_D1];
        path.out[pin_mux_pkg::PIN_D2] = gpio_out[pin_mux_pkg::PIN_D2];
        path.oe[pin_mux_pkg::PIN_D2] = gpio_oe[pin_mux_pkg::PIN_D2];
        path.out[pin_mux_pkg::PIN_D3] = gpio_out[pin_mux_pkg::PIN_D3];
        path.oe[pin_mux_pkg::PIN_D3] = gpio_oe[pin_mux_pkg::PIN_D3];
      end
    endcase
  end

  // Pulldown inhibit bits, one per pin
  assign path.pd_inhibit = pulldown_inhibit_register_1;

  // Input steering; deselected functions see zero
  always_comb begin
    sel_in = pin_in;
    card_cmd_in = 1'h0;
    card_data_in = 4'h0;
    audio_clk_in = 1'h0;
    audio_fs_in = 1'h0;
    audio_rx_in = 1'h0;
    gpio_in = 6'h00;
    unique case (func)
      pin_mux_pkg::FUNC_CARD: begin
        // Card clock is output only; command and data come back
        card_cmd_in = sel_in[pin_mux_pkg::PIN_CMD];
        card_data_in[0] = sel_in[pin_mux_pkg::PIN_D0];
        card_data_in[1] = sel_in[pin_mux_pkg::PIN_D1];
        card_data_in[2] = sel_in[pin_mux_pkg::PIN_D2];
        card_data_in[3] = sel_in[pin_mux_pkg::PIN_D3];
      end
      pin_mux_pkg::FUNC_AUDIO: begin
        audio_clk_in = sel_in[pin_mux_pkg::PIN_CLK];
        audio_fs_in = sel_in[pin_mux_pkg::PIN_CMD];
        audio_rx_in = sel_in[pin_mux_pkg::PIN_D1];
      end
      pin_mux_pkg::FUNC_GPIO: begin
        gpio_in[pin_mux_pkg::PIN_CLK] = sel_in[pin_mux_pkg::PIN_CLK];
        gpio_in[pin_mux_pkg::PIN_CMD] = sel_in[pin_mux_pkg::PIN_CMD];
        gpio_in[pin_mux_pkg::PIN_D0] = sel_in[pin_mux_pkg::PIN_D0];
        gpio_in[pin_mux_pkg::PIN_D1] = sel_in[pin_mux_pkg::PIN_D1];
        gpio_in[pin_mux_pkg::PIN_D2] = sel_in[pin_mux_pkg::PIN_D2];
        gpio_in[pin_mux_pkg::PIN_D3] = sel_in[pin_mux_pkg::PIN_D3];
      end
    endcase
  end

  pin_pad_stage pads (
    .mclk(mclk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .path(path)
  );

  assign pin_out = path.pad_out;
  assign pin_oe = path.pad_oe;
  assign pin_pd_en = path.pad_pd_en;

  // Flag next state; a set wins over either clear
  always_comb begin
    flag_d = flag_q;
    if (flag_set) begin
      flag_d = 1'h1;
    end else if (flag_clear) begin
      flag_d = 1'h0;
    end else if (status1_write) begin
      // Any status register 1 write covers bit 13
      flag_d = status1_wdata[pin_mux_pkg::FLAG_CLEAR_BIT] & 1'h0;
    end
  end

  // Flag register, frozen with the clock enable
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= pin_mux_pkg::FLAG_RESET;
    end else if (clk_en) begin
      flag_q <= flag_d;
    end
  end

  assign external_flag_output = flag_q;
  assign external_flag_oe = ~boundary_scan;

endmodule

// ==== dv/card_port0_pin_mux_properties.sv ====
// Checker for the card port 0 pin mux and flag pin.
// Assumes it is bound to card_port0_pin_mux.
`timescale 1ns/1ps
module card_port0_pin_mux_properties (
  input wire logic mclk, rst_b, clk_en, card_clk_out, audio_fs_out, audio_fs_oe,
  input wire logic audio_tx_out, audio_tx_oe, flag_set, flag_clear, status1_write,
  input wire logic boundary_scan, external_flag_output, external_flag_oe, audio_rx_in,
  input wire logic [1:0] serial_port0_function_select,
  input wire logic [3:0] card_data_oe,
  input wire logic [5:0] pulldown_inhibit_register_1, gpio_out, gpio_oe, pin_out, pin_oe,
  input wire logic [5:0] pin_pd_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire [1:0] sel = serial_port0_function_select;
  sequence s_set;
    clk_en && flag_set;
  endsequence
  sequence s_clr;
    clk_en && !flag_set && (flag_clear || status1_write);
  endsequence
  property p_clk;
    clk_en && sel == 2'h0 |=> pin_oe[0] && pin_out[0] == $past(card_clk_out);
  endproperty
  a_clk: assert property (p_clk) else $error("card clock pin");
  property p_cmd;
    clk_en && sel == 2'h1 |=> pin_oe[1] == $past(audio_fs_oe) && pin_out[1] == $past(audio_fs_out);
  endproperty
  a_cmd: assert property (p_cmd) else $error("frame sync pin");
  property p_gp;
    clk_en && sel[1] |=> pin_oe == $past(gpio_oe) && pin_out == $past(gpio_out);
  endproperty
  a_gp: assert property (p_gp) else $error("general pins");
  property p_tx;
    clk_en && sel == 2'h1 |=> pin_oe[5:3] == 3'h0 && pin_out[2] == $past(audio_tx_out);
  endproperty
  a_tx: assert property (p_tx) else $error("audio data pins");
  property p_bus;
    clk_en && sel == 2'h0 |=> pin_oe[5:2] == $past(card_data_oe);
  endproperty
  a_bus: assert property (p_bus) else $error("card data bus");
  property p_pd;
    clk_en |=> pin_pd_en == (~$past(pulldown_inhibit_register_1) & ~pin_oe);
  endproperty
  a_pd: assert property (p_pd) else $error("pulldown enable");
  property p_set;
    s_set |=> external_flag_output;
  endproperty
  a_set: assert property (p_set) else $error("flag set");
  property p_clr;
    s_clr |=> !external_flag_output;
  endproperty
  a_clr: assert property (p_clr) else $error("flag clear");
  property p_oe;
    external_flag_oe == !boundary_scan;
  endproperty
  a_oe: assert property (p_oe) else $error("flag enable");
  property p_rx;
    sel != 2'h1 |-> !audio_rx_in;
  endproperty
  a_rx: assert property (p_rx) else $error("audio input gated");
endmodule
bind card_port0_pin_mux card_port0_pin_mux_properties u_props (
  .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .card_clk_out(card_clk_out),
  .audio_fs_out(audio_fs_out), .audio_fs_oe(audio_fs_oe), .audio_tx_out(audio_tx_out),
  .audio_tx_oe(audio_tx_oe), .flag_set(flag_set), .flag_clear(flag_clear),
  .status1_write(status1_write), .boundary_scan(boundary_scan),
  .external_flag_output(external_flag_output), .external_flag_oe(external_flag_oe),
  .audio_rx_in(audio_rx_in), .serial_port0_function_select(serial_port0_function_select),
  .card_data_oe(card_data_oe), .pulldown_inhibit_register_1(pulldown_inhibit_register_1),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pd_en(pin_pd_en)
);

// ==== dv/pin_far_side.sv ====
// Far side of the six pins: card, audio part or external logic.
// Assumes released lines fall to the pulldown when it is on.
`timescale 1ns/1ps
module pin_far_side (
  input wire logic mclk,
  input wire logic [5:0] pin_out, pin_oe, pin_pd_en, far_oe, far_val,
  output logic [5:0] pin_in
);
  logic [5:0] toggle_q = 6'h00;
  always_ff @(posedge mclk) toggle_q <= ~toggle_q;
  // Floating lines show a changing pattern
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : far_oe[i] ? far_val[i] : !pin_pd_en[i] & toggle_q[i];
    end
  end
endmodule

// ==== dv/card_port0_pin_mux_and_flag_pin_bench.sv ====
// Bench for the card port 0 pin mux and flag pin.
// Assumes the checker is bound in beside the design.
`timescale 1ns/1ps
module card_port0_pin_mux_and_flag_pin_bench;
  logic mclk = 0, rst_b = 0, clk_en = 1, card_clk_out = 1, card_cmd_out = 1, card_cmd_oe = 1;
  logic audio_clk_out = 1, audio_clk_oe = 1, audio_fs_out = 1, audio_fs_oe = 1;
  logic audio_tx_out = 1, audio_tx_oe = 1, flag_set = 0, flag_clear = 0, status1_write = 0;
  logic boundary_scan = 0, card_cmd_in, audio_clk_in, audio_fs_in, audio_rx_in;
  logic external_flag_output, external_flag_oe;
  logic [1:0] serial_port0_function_select = 2'h0;
  logic [3:0] card_data_out = 4'hA, card_data_oe = 4'hF, card_data_in;
  logic [15:0] status1_wdata = 16'h0000;
  logic [5:0] pulldown_inhibit_register_1 = 6'h00, gpio_out = 6'h2A, gpio_oe = 6'h3F;
  logic [5:0] gpio_in, pin_in, pin_out, pin_oe, pin_pd_en, far_oe = 6'h00, far_val = 6'h00;
  int failures = 0, cmp_count = 0, cycles = 0;
  card_port0_pin_mux u_dut (
    .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
    .serial_port0_function_select(serial_port0_function_select),
    .pulldown_inhibit_register_1(pulldown_inhibit_register_1),
    .card_clk_out(card_clk_out), .card_cmd_out(card_cmd_out), .card_cmd_oe(card_cmd_oe),
    .card_cmd_in(card_cmd_in), .card_data_out(card_data_out), .card_data_oe(card_data_oe),
    .card_data_in(card_data_in), .audio_clk_out(audio_clk_out), .audio_clk_oe(audio_clk_oe),
    .audio_clk_in(audio_clk_in), .audio_fs_out(audio_fs_out), .audio_fs_oe(audio_fs_oe),
    .audio_fs_in(audio_fs_in), .audio_rx_in(audio_rx_in), .audio_tx_out(audio_tx_out),
    .audio_tx_oe(audio_tx_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pd_en(pin_pd_en),
    .flag_set(flag_set), .flag_clear(flag_clear), .status1_write(status1_write),
    .status1_wdata(status1_wdata), .boundary_scan(boundary_scan),
    .external_flag_output(external_flag_output), .external_flag_oe(external_flag_oe)
  );
  pin_far_side u_far (.mclk, .pin_out, .pin_oe, .pin_pd_en, .far_oe, .far_val, .pin_in);
  initial forever #10 mclk = ~mclk;
  task chk(string n, logic [15:0] s, logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task tick(int n = 2);
    repeat (n) @(negedge mclk);
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (++cycles == 2000) begin
      failures++;
      wrap_up();
    end
  end
  task t_card;
    serial_port0_function_select = 2'h0;
    tick();
    chk("card oe", pin_oe, 6'h3F);
    chk("card out", pin_out, 6'h2B);
    card_data_oe = 4'h0;
    far_oe = 6'h3C;
    far_val = 6'h14;
    tick();
    chk("card in", card_data_in, 4'h5);
    chk("gpio gated", gpio_in, 6'h00);
    chk("card cmd in", card_cmd_in, 1'h1);
    chk("audio clk gated", audio_clk_in, 1'h0);
  endtask
  task t_reset;
    rst_b = 0;
    tick(1);
    chk("reset oe", pin_oe, 6'h00);
    chk("reset out", pin_out, 6'h00);
    chk("reset pulldown", pin_pd_en, 6'h3F);
    chk("reset flag", external_flag_output, 1'h1);
    rst_b = 1;
  endtask
  task t_hold;
    clk_en = 0;
    flag_clear = 1;
    serial_port0_function_select = 2'h1;
    tick();
    chk("hold flag", external_flag_output, 1'h1);
    chk("hold oe", pin_oe, 6'h00);
    clk_en = 1;
    tick(1);
    flag_clear = 0;
    chk("run flag", external_flag_output, 1'h0);
    chk("run oe", pin_oe, 6'h07);
  endtask
  task t_audio;
    serial_port0_function_select = 2'h1;
    far_oe = 6'h08;
    far_val = 6'h08;
    tick();
    chk("audio oe", pin_oe, 6'h07);
    chk("audio out", pin_out[2:0], 3'h7);
    chk("audio rx", audio_rx_in, 1'b1);
    chk("card gated", card_data_in, 4'h0);
    chk("audio clk in", audio_clk_in, 1'h1);
    chk("audio fs in", audio_fs_in, 1'h1);
    chk("cmd gated", card_cmd_in, 1'h0);
  endtask
  task t_gpio(logic [1:0] s);
    serial_port0_function_select = s;
    gpio_oe = 6'h3F;
    tick();
    chk("gpio out", pin_out, 6'h2A);
    gpio_oe = 6'h00;
    far_oe = 6'h3F;
    far_val = 6'h15;
    pulldown_inhibit_register_1 = 6'h0F;
    tick();
    chk("gpio in", gpio_in, 6'h15);
    chk("pulldown", pin_pd_en, 6'h30);
    far_oe = 6'h00;
    pulldown_inhibit_register_1 = 6'h00;
  endtask
  task t_flag;
    flag_clear = 1;
    tick(1);
    flag_clear = 0;
    chk("flag clear", external_flag_output, 1'b0);
    flag_set = 1;
    tick(1);
    flag_set = 0;
    chk("flag set", external_flag_output, 1'b1);
    status1_write = 1;
    status1_wdata = 16'h2000;
    tick(1);
    status1_write = 0;
    chk("flag status", external_flag_output, 1'b0);
    flag_set = 1;
    flag_clear = 1;
    tick(1);
    flag_set = 0;
    flag_clear = 0;
    chk("flag set wins", external_flag_output, 1'h1);
    boundary_scan = 1;
    tick(1);
    chk("flag hiz", external_flag_oe, 1'b0);
    boundary_scan = 0;
  endtask
  initial begin
    tick(7);
    t_reset();
    t_card();
    t_audio();
    t_gpio(2'h2);
    t_gpio(2'h3);
    t_flag();
    t_hold();
    t_reset();
    t_audio();
    wrap_up();
  end
endmodule
